// ### hdl/mosc_ctrl.sv
// Option decode, clear-to-send timing, squelch and APB register block
//
// Register access over APB and the register offsets were left to the implementer.
`timescale 1ns/1ps
module mosc_ctrl #(
  parameter int TICK_CYCLES = mosc_pkg::CYC_PER_US
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [mosc_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rts_in,
  input wire logic new_sync_input,
  input wire logic energy_detect_in,
  output logic cts_out,
  output logic carrier_detect_out,
  output logic squelch_clamp_o,
  output logic squelch_clamp_oe,
  output logic threshold_select_out_o,
  output logic threshold_select_out_oe,
  output logic scrambler_enable,
  output logic pattern_guard_enable
);

  mosc_pkg::mosc_state_t st_r;
  mosc_pkg::mosc_state_t st_nxt;
  mosc_pkg::mosc_cfg_t c;
  mosc_pkg::mosc_stat_t stat_w;
  logic [3:0] seq_w;
  logic tick;
  logic cfg_hit;
  logic stat_hit;
  logic rts_rise;
  logic rts_fall;
  logic ext_cond;
  logic cts_start;
  logic cts_expired;
  logic cts_busy;
  logic ext_start;
  logic ext_busy;

  assign c = st_r.cfg;

  // ============================================================
  // Turn-on sequence decode, first matching row wins
  function automatic logic [3:0] seq_of(input mosc_pkg::mosc_cfg_t f);
    logic y;
    logic l;
    logic k;
    logic h;
    logic w;
    logic e;
    y = f.answer_tone_select;
    l = f.long_delay_select;
    k = f.ready_delay_select;
    h = f.hold_timing_input;
    w = f.tx_wire_mode_select;
    e = f.extension_select;
    seq_of = mosc_pkg::SEQ_NONE;
    if (!y && l) begin
      if (f.scrambler_insert) begin
        seq_of = mosc_pkg::SEQ_08;
      end else if (w) begin
        seq_of = mosc_pkg::SEQ_01;
      end else begin
        seq_of = mosc_pkg::SEQ_07;
      end
    end else if (y && !l) begin
      seq_of = f.scrambler_insert ? mosc_pkg::SEQ_12 : mosc_pkg::SEQ_11;
    end else if (y && l) begin
      if (w && !k && !f.scrambler_insert) begin
        seq_of = h ? mosc_pkg::SEQ_02 : mosc_pkg::SEQ_03;
      end else if (w && !k) begin
        seq_of = mosc_pkg::SEQ_04;
      end else if ((h && !w && !e) || (k && h && w)) begin
        seq_of = f.scrambler_insert ? mosc_pkg::SEQ_06 : mosc_pkg::SEQ_05;
      end else if ((k && !h) || (!w && e) || (!h && !w)) begin
        seq_of = f.scrambler_insert ? mosc_pkg::SEQ_10 : mosc_pkg::SEQ_09;
      end
    end
  endfunction

  assign seq_w = seq_of(c);

  // ============================================================
  // Microsecond tick divider
  localparam int DIV_W_T = mosc_pkg::DIV_W;
  assign tick = (st_r.div == DIV_W_T'(TICK_CYCLES - 1));

  // ============================================================
  // Edges of request-to-send and timer starts
  assign rts_rise = rts_in && !st_r.rts_d;
  assign rts_fall = !rts_in && st_r.rts_d;
  assign ext_cond = new_sync_input && !c.tx_wire_mode_select && c.squelch_enable;
  assign cts_start = (st_r.cts_st == mosc_pkg::CTS_IDLE) && rts_in;
  assign ext_start = rts_fall && ext_cond && c.extension_select;

  mosc_timer u_cts_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .start(cts_start),
    .stop(!rts_in),
    .tick(tick),
    .load_val(mosc_pkg::mosc_seq_us(seq_w)),
    .busy(cts_busy),
    .expired(cts_expired)
  );

  mosc_timer u_ext_tmr (
    .pclk(pclk),
    .presetn(presetn),
    .start(ext_start),
    .stop(rts_rise),
    .tick(tick),
    .load_val(mosc_pkg::US_EXT_SQ),
    .busy(ext_busy),
    .expired()
  );

  // ============================================================
  // APB decode
  assign cfg_hit = (paddr == mosc_pkg::CFG_ADDR);
  assign stat_hit = (paddr == mosc_pkg::STAT_ADDR);

  always_comb begin
    stat_w = '0;
    stat_w.seq = seq_w;
    stat_w.ext_busy = ext_busy;
    stat_w.cts_wait = cts_busy;
    stat_w.carrier_detect = st_r.cd;
    stat_w.squelch = st_r.sq;
    stat_w.cts = st_r.cts_o;
  end

  // ============================================================
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rts_d = rts_in;
    st_nxt.div = tick ? '0 : st_r.div + DIV_W_T'(1);
    if (psel && !penable) begin
      st_nxt.rdata = '0;
      if (cfg_hit) begin
        st_nxt.rdata[mosc_pkg::CFG_W-1:0] = st_r.cfg;
      end else if (stat_hit) begin
        st_nxt.rdata[mosc_pkg::STAT_W-1:0] = stat_w;
      end
    end
    if (psel && penable && pwrite && cfg_hit) begin
      st_nxt.cfg = pwdata[mosc_pkg::CFG_W-1:0];
    end
    unique case (st_r.cts_st)
      mosc_pkg::CTS_IDLE: begin
        if (rts_in) begin
          st_nxt.cts_st = mosc_pkg::CTS_WAIT;
        end
      end
      mosc_pkg::CTS_WAIT: begin
        if (!rts_in) begin
          st_nxt.cts_st = mosc_pkg::CTS_IDLE;
        end else if (cts_expired) begin
          st_nxt.cts_st = mosc_pkg::CTS_ON;
        end
      end
      mosc_pkg::CTS_ON: begin
        if (!rts_in) begin
          st_nxt.cts_st = mosc_pkg::CTS_IDLE;
        end
      end
      default: st_nxt.cts_st = mosc_pkg::CTS_IDLE;
    endcase
    st_nxt.cts_o = (st_nxt.cts_st == mosc_pkg::CTS_ON);
    if (!new_sync_input) begin
      st_nxt.sq = 1'h1;
    end else if (c.tx_wire_mode_select) begin
      st_nxt.sq = 1'h0;
    end else if (!c.squelch_enable) begin
      st_nxt.sq = 1'h0;
    end else begin
      st_nxt.sq = rts_in || ext_start || ext_busy;
    end
    st_nxt.cd = energy_detect_in && !st_nxt.sq;
    st_nxt.thr_oe = c.threshold_option_input && c.rx_wire_mode_select;
    st_nxt.scr = c.scrambler_insert;
    st_nxt.grd = c.scrambler_insert && !c.pattern_guard_select;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.cfg <= mosc_pkg::CFG_RESET;
      st_r.cts_st <= mosc_pkg::CTS_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ============================================================
  // Outputs
  assign prdata = st_r.rdata;
  assign pready = 1'h1;
  assign pslverr = psel && penable && !(cfg_hit || stat_hit);
  assign cts_out = st_r.cts_o;
  assign carrier_detect_out = st_r.cd;
  assign squelch_clamp_o = 1'h0;
  assign squelch_clamp_oe = st_r.sq;
  assign threshold_select_out_o = 1'h0;
  assign threshold_select_out_oe = st_r.thr_oe;
  assign scrambler_enable = st_r.scr;
  assign pattern_guard_enable = st_r.grd;

  // ============================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence rts_fall_s;
    rts_fall && new_sync_input && !c.tx_wire_mode_select && c.squelch_enable;
  endsequence

  sequence ext_hold_s;
    ext_busy && squelch_clamp_oe;
  endsequence

  seq_one_a: assert property (!c.answer_tone_select && c.long_delay_select && c.tx_wire_mode_select
    && !c.scrambler_insert |-> seq_w == mosc_pkg::SEQ_01) else $error("sequence 1 not chosen");
  seq_two_a: assert property (c.answer_tone_select && c.long_delay_select && !c.ready_delay_select
    && c.hold_timing_input && c.tx_wire_mode_select && !c.scrambler_insert
    |-> seq_w == mosc_pkg::SEQ_02) else $error("sequence 2 not chosen");
  seq_four_a: assert property (c.answer_tone_select && c.long_delay_select && !c.ready_delay_select
    && c.tx_wire_mode_select && c.scrambler_insert
    |-> seq_w == mosc_pkg::SEQ_04) else $error("sequence 4 not chosen");
  seq_seven_a: assert property (!c.answer_tone_select && c.long_delay_select && !c.tx_wire_mode_select
    && !c.scrambler_insert |-> seq_w == mosc_pkg::SEQ_07) else $error("sequence 7 not chosen");
  seq_twelve_a: assert property (c.answer_tone_select && !c.long_delay_select && c.scrambler_insert
    |-> mosc_pkg::mosc_seq_us(seq_w) == mosc_pkg::US_SEQ12) else $error("auto-call delay wrong");
  cts_on_a: assert property ($rose(cts_out) |-> $past(cts_expired) && $past(rts_in))
    else $error("clear-to-send rose without delay");
  cts_drop_a: assert property (!rts_in |=> !cts_out) else $error("clear-to-send not dropped");
  new_sync_input_sq_a: assert property (!new_sync_input |=> squelch_clamp_oe && !carrier_detect_out)
    else $error("no squelch while new sync low");
  four_wire_a: assert property (new_sync_input && c.tx_wire_mode_select |=> !squelch_clamp_oe)
    else $error("squelch in 4-wire mode");
  sq_disable_a: assert property (new_sync_input && !c.tx_wire_mode_select && !c.squelch_enable
    |=> !squelch_clamp_oe) else $error("squelch while disabled");
  rts_sq_a: assert property (new_sync_input && !c.tx_wire_mode_select && c.squelch_enable && rts_in
    |=> squelch_clamp_oe) else $error("no squelch during request-to-send");
  ext_sq_a: assert property (rts_fall_s ##0 c.extension_select ##1 new_sync_input
    |-> ext_hold_s) else $error("extended squelch missing");
  no_ext_a: assert property (rts_fall_s ##0 !c.extension_select && !ext_busy |=> !squelch_clamp_oe)
    else $error("squelch kept after request-to-send");
  clamp_cd_a: assert property (squelch_clamp_oe |-> !carrier_detect_out && !squelch_clamp_o)
    else $error("carrier detect on during squelch");
  thr_pin_a: assert property (##1 threshold_select_out_oe
    == $past(c.threshold_option_input && c.rx_wire_mode_select) && !threshold_select_out_o)
    else $error("threshold pin wrong");
  scr_off_a: assert property (!c.scrambler_insert |=> !scrambler_enable && !pattern_guard_enable)
    else $error("scrambler not bypassed");
  scr_on_a: assert property (c.scrambler_insert |=> scrambler_enable
    && pattern_guard_enable == !$past(c.pattern_guard_select)) else $error("guard select wrong");

endmodule

// ### hdl/mosc_pkg.sv
// Constants and types for the modem option decode and carrier-detect squelch control block
// ============================================================
package mosc_pkg;

  // ============================================================
  // Clock and timebase
  localparam real CLK_PERIOD_NS = 20.0;
  localparam int CYC_PER_US = int'(1000.0 / CLK_PERIOD_NS);
  localparam int DIV_W = 6;
  localparam int DLY_W = 20;

  // ============================================================
  // Delays in milliseconds and in microsecond ticks
  localparam real T_SEQ1_MS = 6.67;
  localparam real T_SEQ2_MS = 8.33;
  localparam real T_SEQ3_MS = 30.0;
  localparam real T_SEQ5_MS = 90.0;
  localparam real T_SEQ7_MS = 148.3;
  localparam real T_SEQ9_MS = 220.0;
  localparam real T_SEQ12_MS = 800.0;
  localparam real T_EXT_SQ_MS = 148.3;
  localparam logic [DLY_W-1:0] US_SEQ1 = DLY_W'(int'(T_SEQ1_MS * 1000.0));
  localparam logic [DLY_W-1:0] US_SEQ2 = DLY_W'(int'(T_SEQ2_MS * 1000.0));
  localparam logic [DLY_W-1:0] US_SEQ3 = DLY_W'(int'(T_SEQ3_MS * 1000.0));
  localparam logic [DLY_W-1:0] US_SEQ5 = DLY_W'(int'(T_SEQ5_MS * 1000.0));
  localparam logic [DLY_W-1:0] US_SEQ7 = DLY_W'(int'(T_SEQ7_MS * 1000.0));
  localparam logic [DLY_W-1:0] US_SEQ9 = DLY_W'(int'(T_SEQ9_MS * 1000.0));
  localparam logic [DLY_W-1:0] US_SEQ12 = DLY_W'(int'(T_SEQ12_MS * 1000.0));
  localparam logic [DLY_W-1:0] US_EXT_SQ = DLY_W'(int'(T_EXT_SQ_MS * 1000.0));

  // ============================================================
  // Turn-on sequence numbers
  localparam logic [3:0] SEQ_NONE = 4'h0;
  localparam logic [3:0] SEQ_01 = 4'h1;
  localparam logic [3:0] SEQ_02 = 4'h2;
  localparam logic [3:0] SEQ_03 = 4'h3;
  localparam logic [3:0] SEQ_04 = 4'h4;
  localparam logic [3:0] SEQ_05 = 4'h5;
  localparam logic [3:0] SEQ_06 = 4'h6;
  localparam logic [3:0] SEQ_07 = 4'h7;
  localparam logic [3:0] SEQ_08 = 4'h8;
  localparam logic [3:0] SEQ_09 = 4'h9;
  localparam logic [3:0] SEQ_10 = 4'hA;
  localparam logic [3:0] SEQ_11 = 4'hB;
  localparam logic [3:0] SEQ_12 = 4'hC;

  // ============================================================
  // Register map
  localparam int AW = 12;
  localparam logic [AW-1:0] CFG_ADDR = 12'h000;
  localparam logic [AW-1:0] STAT_ADDR = 12'h004;
  localparam int CFG_W = 11;
  localparam int STAT_W = 9;
  localparam logic [CFG_W-1:0] CFG_RESET = 11'h000;

  typedef struct packed {
    logic rx_wire_mode_select;
    logic threshold_option_input;
    logic pattern_guard_select;
    logic squelch_enable;
    logic extension_select;
    logic scrambler_insert;
    logic tx_wire_mode_select;
    logic hold_timing_input;
    logic ready_delay_select;
    logic long_delay_select;
    logic answer_tone_select;
  } mosc_cfg_t;

  typedef struct packed {
    logic [3:0] seq;
    logic ext_busy;
    logic cts_wait;
    logic carrier_detect;
    logic squelch;
    logic cts;
  } mosc_stat_t;

  typedef enum logic [1:0] {
    CTS_IDLE = 2'b00,
    CTS_WAIT = 2'b01,
    CTS_ON = 2'b10
  } mosc_cts_t;

  typedef struct packed {
    mosc_cfg_t cfg;
    logic [31:0] rdata;
    mosc_cts_t cts_st;
    logic [DIV_W-1:0] div;
    logic rts_d;
    logic sq;
    logic cd;
    logic cts_o;
    logic thr_oe;
    logic scr;
    logic grd;
  } mosc_state_t;

  typedef struct packed {
    logic [DLY_W-1:0] cnt;
    logic run;
    logic expired;
  } mosc_tmr_t;

  // Turn-on delay of each sequence
  function automatic logic [DLY_W-1:0] mosc_seq_us(input logic [3:0] s);
    unique case (s)
      SEQ_01: mosc_seq_us = US_SEQ1;
      SEQ_02: mosc_seq_us = US_SEQ2;
      SEQ_03, SEQ_04: mosc_seq_us = US_SEQ3;
      SEQ_05, SEQ_06: mosc_seq_us = US_SEQ5;
      SEQ_07, SEQ_08: mosc_seq_us = US_SEQ7;
      SEQ_09, SEQ_10, SEQ_11: mosc_seq_us = US_SEQ9;
      default: mosc_seq_us = US_SEQ12;
    endcase
  endfunction

endpackage

// ### hdl/mosc_timer.sv
// Microsecond delay counter with start, stop and expiry pulse
`timescale 1ns/1ps
module mosc_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic stop,
  input wire logic tick,
  input wire logic [mosc_pkg::DLY_W-1:0] load_val,
  output logic busy,
  output logic expired
);

  mosc_pkg::mosc_tmr_t st_r;
  mosc_pkg::mosc_tmr_t st_nxt;

  // ============================================================
  // Count down one step per tick
  always_comb begin
    st_nxt = st_r;
    st_nxt.expired = 1'h0;
    if (start) begin
      st_nxt.cnt = load_val;
      st_nxt.run = 1'h1;
    end else if (stop) begin
      st_nxt.run = 1'h0;
    end else if (st_r.run && tick) begin
      if (st_r.cnt <= mosc_pkg::DLY_W'(1)) begin
        st_nxt.run = 1'h0;
        st_nxt.expired = 1'h1;
      end else begin
        st_nxt.cnt = st_r.cnt - mosc_pkg::DLY_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy = st_r.run;
  assign expired = st_r.expired;

  // ============================================================
  // Checks
  tmr_start_a: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> busy && !expired) else $error("timer not running after start");

endmodule

// ### sim/mosc_dte.sv
// Data terminal model driving request-to-send, new sync and line energy
`timescale 1ns/1ps
module mosc_dte (
  input wire logic pclk,
  input wire logic rts_req,
  input wire logic sync_req,
  input wire logic energy_req,
  input wire logic cts_out,
  output logic rts_in,
  output logic new_sync_input,
  output logic energy_detect_in,
  output logic [31:0] cts_lat
);
  // ============================================================
  // Pins follow the commands one edge later
  initial begin
    rts_in = 1'b0;
    new_sync_input = 1'b1;
    energy_detect_in = 1'b0;
    cts_lat = 32'h0000_0000;
  end

  always @(posedge pclk) begin
    rts_in <= rts_req;
    new_sync_input <= sync_req;
    energy_detect_in <= energy_req;
    // Cycles spent waiting for clear-to-send
    if (!rts_in) begin
      cts_lat <= 32'h0000_0000;
    end else if (!cts_out) begin
      cts_lat <= cts_lat + 32'h0000_0001;
    end
  end
endmodule

// ### sim/mosc_ctrl_tb_top.sv
// Self-checking bench for option decode, clear-to-send timing and squelch
`timescale 1ns/1ps
module mosc_ctrl_tb_top;
  localparam int TICK = 1;
  typedef struct packed {
    logic [10:0] cfg;
    logic [3:0] seq;
    logic scr;
    logic grd;
    logic thr;
    logic [19:0] dly;
  } mosc_row_t;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [mosc_pkg::AW-1:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rts_req = 1'b0;
  logic sync_req = 1'b1;
  logic energy_req = 1'b1;
  logic rts_in;
  logic new_sync_input;
  logic energy_detect_in;
  logic [31:0] cts_lat;
  logic cts_out;
  logic carrier_detect_out;
  logic squelch_clamp_o;
  logic squelch_clamp_oe;
  logic threshold_select_out_o;
  logic threshold_select_out_oe;
  logic scrambler_enable;
  logic pattern_guard_enable;
  int n_fail = 0;
  int compares = 0;
  mosc_row_t rows [13];
  logic [31:0] rd;
  logic err;
  int n;
  int expc;

  always #10 pclk = ~pclk;

  mosc_ctrl #(.TICK_CYCLES(TICK)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rts_in(rts_in), .new_sync_input(new_sync_input), .energy_detect_in(energy_detect_in),
    .cts_out(cts_out), .carrier_detect_out(carrier_detect_out), .squelch_clamp_o(squelch_clamp_o),
    .squelch_clamp_oe(squelch_clamp_oe), .threshold_select_out_o(threshold_select_out_o),
    .threshold_select_out_oe(threshold_select_out_oe), .scrambler_enable(scrambler_enable),
    .pattern_guard_enable(pattern_guard_enable));

  mosc_dte dte (.pclk(pclk), .rts_req(rts_req), .sync_req(sync_req), .energy_req(energy_req),
    .cts_out(cts_out), .rts_in(rts_in), .new_sync_input(new_sync_input),
    .energy_detect_in(energy_detect_in), .cts_lat(cts_lat));

  // ============================================================
  // Shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [mosc_pkg::AW-1:0] a, input logic [31:0] wd,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic drv(input logic r, input logic s);
    @(posedge pclk);
    rts_req <= r;
    sync_req <= s;
  endtask

  task automatic sq(input logic [10:0] c, input logic r, input logic s, input logic exp);
    apb(1'b1, mosc_pkg::CFG_ADDR, {21'h000000, c}, rd, err);
    drv(r, s);
    settle(4);
    chk(32'(squelch_clamp_oe), 32'(exp));
    chk(32'(carrier_detect_out), 32'(!exp));
    chk(32'(squelch_clamp_o), 32'h0000_0000);
  endtask

  task automatic conclude();
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ============================================================
  // Watchdog
  initial begin
    repeat (80000) @(posedge pclk);
    n_fail++;
    conclude();
  end

  // ============================================================
  // Main sequence
  initial begin
    rows[0] = '{11'h012, mosc_pkg::SEQ_01, 1'b0, 1'b0, 1'b0, mosc_pkg::US_SEQ1};
    rows[1] = '{11'h41B, mosc_pkg::SEQ_02, 1'b0, 1'b0, 1'b0, mosc_pkg::US_SEQ2};
    rows[2] = '{11'h233, mosc_pkg::SEQ_04, 1'b1, 1'b1, 1'b0, mosc_pkg::US_SEQ3};
    rows[3] = '{11'h002, mosc_pkg::SEQ_07, 1'b0, 1'b0, 1'b0, 20'h00000};
    rows[4] = '{11'h721, mosc_pkg::SEQ_12, 1'b1, 1'b0, 1'b1, 20'h00000};
    rows[5] = '{11'h112, mosc_pkg::SEQ_01, 1'b0, 1'b0, 1'b0, 20'h00000};
    rows[6] = '{11'h013, mosc_pkg::SEQ_03, 1'b0, 1'b0, 1'b0, 20'h00000};
    rows[7] = '{11'h00B, mosc_pkg::SEQ_05, 1'b0, 1'b0, 1'b0, 20'h00000};
    rows[8] = '{11'h03F, mosc_pkg::SEQ_06, 1'b1, 1'b1, 1'b0, 20'h00000};
    rows[9] = '{11'h022, mosc_pkg::SEQ_08, 1'b1, 1'b1, 1'b0, 20'h00000};
    rows[10] = '{11'h007, mosc_pkg::SEQ_09, 1'b0, 1'b0, 1'b0, 20'h00000};
    rows[11] = '{11'h063, mosc_pkg::SEQ_10, 1'b1, 1'b1, 1'b0, 20'h00000};
    rows[12] = '{11'h001, mosc_pkg::SEQ_11, 1'b0, 1'b0, 1'b0, 20'h00000};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, mosc_pkg::CFG_ADDR, 32'h0000_0000, rd, err);
    chk(rd, 32'(mosc_pkg::CFG_RESET));
    foreach (rows[i]) begin
      apb(1'b1, mosc_pkg::CFG_ADDR, {21'h000000, rows[i].cfg}, rd, err);
      settle(2);
      chk(32'(scrambler_enable), 32'(rows[i].scr));
      chk(32'(pattern_guard_enable), 32'(rows[i].grd));
      chk(32'(threshold_select_out_oe), 32'(rows[i].thr));
      chk(32'(threshold_select_out_o), 32'h0000_0000);
      apb(1'b0, mosc_pkg::STAT_ADDR, 32'h0000_0000, rd, err);
      chk({28'h0000000, rd[8:5]}, {28'h0000000, rows[i].seq});
      if (rows[i].dly != 20'h00000) begin
        // Short request first, dropped and raised again: the count must restart
        drv(1'b1, 1'b1);
        repeat (1000) @(posedge pclk);
        drv(1'b0, 1'b1);
        repeat (4) @(posedge pclk);
        drv(1'b1, 1'b1);
        expc = int'(rows[i].dly) * TICK;
        n = 0;
        while (cts_out !== 1'b1 && n < expc + 20) begin
          n++;
          @(negedge pclk);
        end
        chk(32'((cts_lat >= expc - 2) && (cts_lat <= expc + 3)), 32'h0000_0001);
        drv(1'b0, 1'b1);
        settle(2);
        chk(32'(cts_out), 32'h0000_0000);
      end
    end
    // ============================================================
    // Squelch table
    sq(11'h010, 1'b1, 1'b0, 1'b1);
    sq(11'h090, 1'b1, 1'b1, 1'b0);
    sq(11'h040, 1'b1, 1'b1, 1'b0);
    sq(11'h0C0, 1'b1, 1'b1, 1'b1);
    drv(1'b0, 1'b1);
    settle(1000);
    chk(32'(squelch_clamp_oe), 32'h0000_0001);
    chk(32'(carrier_detect_out), 32'h0000_0000);
    apb(1'b0, mosc_pkg::STAT_ADDR, 32'h0000_0000, rd, err);
    chk(32'(rd[4]), 32'h0000_0001);
    sq(11'h080, 1'b1, 1'b1, 1'b1);
    drv(1'b0, 1'b1);
    settle(3);
    chk(32'(squelch_clamp_oe), 32'h0000_0000);
    chk(32'(carrier_detect_out), 32'h0000_0001);
    // ============================================================
    // Register bus corner cases
    apb(1'b1, mosc_pkg::CFG_ADDR, 32'hFFFF_FFFF, rd, err);
    apb(1'b1, 12'h008, 32'h0000_0000, rd, err);
    chk(32'(err), 32'h0000_0001);
    apb(1'b0, 12'h008, 32'h0000_0000, rd, err);
    chk(rd, 32'h0000_0000);
    apb(1'b0, mosc_pkg::CFG_ADDR, 32'h0000_0000, rd, err);
    chk(rd, 32'h0000_07FF);
    settle(2);
    chk(32'(threshold_select_out_oe), 32'h0000_0001);
    // ============================================================
    // Reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    settle(2);
    chk(32'(cts_out), 32'h0000_0000);
    chk(32'(threshold_select_out_oe), 32'h0000_0000);
    chk(32'(scrambler_enable), 32'h0000_0000);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, mosc_pkg::CFG_ADDR, 32'h0000_0000, rd, err);
    chk(rd, 32'(mosc_pkg::CFG_RESET));
    conclude();
  end
endmodule
